// >>> core/rsc_pkg.sv
// Constants, register map and types for the reset source controller
`default_nettype none
package rsc_pkg;
  // System clock period in ns
  localparam int unsigned CLK_PERIOD_NS = 4;
  // Least stretch of internal reset after the last source drops, in ns
  localparam int unsigned RST_HOLD_NS = 100;
  // Stretch as a cycle count, rounded up
  localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least width of a software peripheral reset pulse, in ns
  localparam int unsigned PRST_HOLD_NS = 40;
  // Peripheral pulse as a cycle count, rounded up
  localparam int unsigned PRST_HOLD_CYC = (PRST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] OFS_IDENT_A = 8'h00;
  localparam logic [7:0] OFS_IDENT_B = 8'h04;
  localparam logic [7:0] OFS_CAP0 = 8'h08;
  localparam logic [7:0] OFS_CAP4 = 8'h18;
  localparam logic [7:0] OFS_BOR_CTRL = 8'h1C;
  localparam logic [7:0] OFS_CAUSE = 8'h20;
  localparam logic [7:0] OFS_CORE_CTRL = 8'h24;
  localparam logic [7:0] OFS_PRST = 8'h28;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h34;

  // Reset-cause field layout
  localparam int unsigned CAUSE_W = 5;
  localparam int unsigned CAUSE_EXT_BIT = 0;
  localparam int unsigned CAUSE_POR_BIT = 1;
  localparam int unsigned CAUSE_BOR_BIT = 2;
  localparam int unsigned CAUSE_WDT_BIT = 3;
  localparam int unsigned CAUSE_SW_BIT = 4;
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 5'h00;

  // Brown-out control: reset-enable bit
  localparam int unsigned BOR_RSTEN_BIT = 1;
  localparam logic BOR_RSTEN_RST = 1'b0;
  // Core control: system reset request bit
  localparam int unsigned SYS_REQ_BIT = 2;

  // Interrupt status and mask layout
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_BOR_BIT = 0;
  localparam int unsigned IRQ_PRST_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

  // Synchroniser lane order
  localparam int unsigned SY_POR = 0;
  localparam int unsigned SY_EXT_B = 1;
  localparam int unsigned SY_BOR = 2;
  localparam int unsigned SY_WDT = 3;
  // Synchroniser value under controller reset: power-on active, pin released
  localparam logic [3:0] SYNC_RST = 4'h3;

  // Release and boot-fetch sequence
  typedef enum logic [2:0] {
    BOOT_HOLD,
    BOOT_SP,
    BOOT_PC,
    BOOT_INSN,
    BOOT_RUN
  } rsc_boot_e;
endpackage : rsc_pkg
`default_nettype wire

// >>> core/rsc_reset_ctrl.sv
// Reset source controller: source gathering, domain resets, boot sequence, registers
//
// Notes on behaviour
// [RQ1] Exactly five reset sources are accepted
// [RQ2] Power-on resets core, test port, peripherals
// [RQ3] Pin reset spares test port, only its pins
// [RQ4] Brown-out, system request, watchdog spare test port
// [RQ5] System reset via core control request bit
// [RQ6] Peripheral reset touches only chosen peripherals
// [RQ7] Cause bit set per reset, sticky
// [RQ8] Power-on or pin cause clears other causes
// [RQ9] Hold until detector drops, then boot fetches
// [RQ10] Power-on source acts on first power-up only
// [RQ11] Pin pulse released, then release and boot
// [RQ12] Long pin hold keeps device in reset
// [RQ13] Identification registers are read-only
// [RQ14] Brown-out level reset, only when enabled
// [RQ15] Peripheral bit set then cleared pulses reset
// [RQ16] Asynchronous sources synchronised before release
`default_nettype none
module rsc_reset_ctrl
  import rsc_pkg::*;
#(
  parameter int unsigned NPERIPH = 32,
  parameter logic [31:0] IDENT_A = 32'h0000_0001, // Arbitrary value
  parameter logic [31:0] IDENT_B = 32'h0000_0002, // Arbitrary value
  parameter logic [31:0] CAP0 = 32'h0000_0000,
  parameter logic [31:0] CAP1 = 32'h0000_0000,
  parameter logic [31:0] CAP2 = 32'h0000_0000,
  parameter logic [31:0] CAP3 = 32'h0000_0000,
  parameter logic [31:0] CAP4 = 32'h0000_0000
) (
  // Clock and controller reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_B_IN,
  // Reset sources
  input wire logic POR_DET_IN,
  input wire logic EXT_RST_B_IN,
  input wire logic BOR_DET_IN,
  input wire logic WDT_RST_IN,
  // Domain resets
  output logic CORE_RST_B_OUT,
  output logic TAP_RST_B_OUT,
  output logic TAP_PIN_RST_B_OUT,
  output logic [NPERIPH-1:0] PERIPH_RST_B_OUT,
  // Boot sequence
  output logic FETCH_SP_OUT,
  output logic FETCH_PC_OUT,
  output logic FETCH_INSN_OUT,
  output logic CORE_RUN_OUT,
  // Avalon-MM slave
  input wire logic [7:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  // Interrupt
  output logic IRQ_OUT
);
  import rsc_pkg::*;

  // Counter widths follow the package cycle counts, so a longer stretch
  // only needs a new constant there, never a change in this file
  // Counter width for the reset stretch
  localparam int unsigned HW = $clog2(RST_HOLD_CYC + 1);
  // Counter width for the peripheral pulse
  localparam int unsigned PW = $clog2(PRST_HOLD_CYC + 1);

  // Refuse peripheral counts that one register cannot hold
  if (NPERIPH < 1 || NPERIPH > 32) begin : g_chk
    $error("NPERIPH must lie in 1..32");
  end

  // Whole state of the block
  typedef struct packed {
    logic [3:0] sync1; // First synchroniser stage
    logic [3:0] sync2; // Second synchroniser stage
    logic por_done; // Power-on detector has dropped once
    logic bor_prev; // Brown-out level one cycle ago
    logic wdt_prev; // Watchdog level one cycle ago
    logic por_flag; // Current reset includes power-on
    logic ext_flag; // Current reset includes the pin
    logic [HW-1:0] hold_cnt; // Release stretch counter
    rsc_boot_e boot; // Release and boot state
    logic [CAUSE_W-1:0] cause; // Sticky reset cause
    logic bor_en; // Brown-out reset enable
    logic sys_req; // One-cycle system reset request
    logic [NPERIPH-1:0] prst_reg; // Software peripheral reset bits
    logic [NPERIPH-1:0] prst_act; // Peripherals in a reset pulse
    logic [PW-1:0] prst_cnt; // Peripheral pulse counter
    logic [IRQ_W-1:0] irq_stat; // Sticky interrupt status
    logic [IRQ_W-1:0] irq_mask; // Interrupt mask
    logic irq; // Registered interrupt
    logic core_rst_b; // Core reset
    logic tap_rst_b; // Test port reset
    logic tap_pin_rst_b; // Test port pin configuration reset
    logic [NPERIPH-1:0] periph_rst_b; // Peripheral resets
    logic fetch_sp; // Stack pointer fetch strobe
    logic fetch_pc; // Program counter fetch strobe
    logic fetch_insn; // First instruction fetch strobe
    logic run; // Core executing
    logic waitreq; // Bus wait
    logic [31:0] rdata; // Bus read data
  } rsc_st_s;

  rsc_st_s s_q; // Registered state
  rsc_st_s s_d; // Next state

  // Capability registers as a table
  localparam logic [4:0][31:0] CAP_TAB = {CAP4, CAP3, CAP2, CAP1, CAP0};

  // Next-state logic
  always_comb begin
    logic por_a; // Live power-on source
    logic ext_a; // Live pin source
    logic bor_a; // Live brown-out source
    logic wdt_ev; // Watchdog request edge
    logic src; // Any source this cycle
    logic in_rst; // Internal reset asserted
    logic wr_acc; // Write taking effect this edge
    logic [31:0] wmask; // Byte-enable mask
    logic [31:0] wval; // Masked write data
    logic [NPERIPH-1:0] prst_new; // Peripheral bits after a write
    logic [NPERIPH-1:0] falls; // Peripheral bits just cleared
    logic [IRQ_W-1:0] irq_ev; // Interrupt events
    logic [31:0] rd; // Read mux
    por_a = 1'b0;
    ext_a = 1'b0;
    bor_a = 1'b0;
    wdt_ev = 1'b0;
    src = 1'b0;
    in_rst = 1'b0;
    wr_acc = 1'b0;
    wmask = 32'h0000_0000;
    wval = 32'h0000_0000;
    prst_new = s_q.prst_reg;
    falls = '0;
    irq_ev = '0;
    rd = 32'h0000_0000;
    s_d = s_q;

    // Two-flop synchronisers on every asynchronous source
    s_d.sync1 = {WDT_RST_IN, BOR_DET_IN, EXT_RST_B_IN, POR_DET_IN}; // see [RQ16]
    s_d.sync2 = s_q.sync1; // see [RQ16]

    // Power-on counts only until the detector first drops
    por_a = s_q.sync2[SY_POR] & ~s_q.por_done; // see [RQ10]
    s_d.por_done = s_q.por_done | ~s_q.sync2[SY_POR]; // see [RQ10]
    ext_a = ~s_q.sync2[SY_EXT_B]; // see [RQ11] [RQ12]
    bor_a = s_q.sync2[SY_BOR] & s_q.bor_en; // see [RQ14]
    wdt_ev = s_q.sync2[SY_WDT] & ~s_q.wdt_prev;
    s_d.wdt_prev = s_q.sync2[SY_WDT];
    s_d.bor_prev = s_q.sync2[SY_BOR];
    // Five sources, nothing else starts a system reset
    src = por_a | ext_a | bor_a | wdt_ev | s_q.sys_req; // see [RQ1]

    // Stretch restarts while any source is live
    // A live level source keeps reloading the counter, so a held pin or a
    // long brown-out keeps the core and every peripheral in reset however long it lasts; the
    // counter only runs down once all sources are quiet
    if (src) begin
      s_d.hold_cnt = HW'(RST_HOLD_CYC);
    end else if (s_q.hold_cnt != '0) begin
      s_d.hold_cnt = s_q.hold_cnt - 1'b1;
    end
    in_rst = src | (s_q.hold_cnt != '0); // see [RQ9] [RQ12] [RQ14]

    // Remember which sources took part in this reset
    if (in_rst) begin
      s_d.por_flag = s_q.por_flag | por_a;
      s_d.ext_flag = s_q.ext_flag | ext_a;
    end else begin
      s_d.por_flag = 1'b0;
      s_d.ext_flag = 1'b0;
    end

    // Release and boot-fetch sequence
    // A source arriving mid-sequence sends it back to the hold state at once,
    // so the core never sees a half-finished boot; each fetch strobe stands
    // for exactly one cycle and needs no answer
    if (in_rst) begin
      s_d.boot = BOOT_HOLD; // see [RQ9]
    end else begin
      case (s_q.boot)
        BOOT_HOLD: s_d.boot = BOOT_SP; // see [RQ9] [RQ11]
        BOOT_SP: s_d.boot = BOOT_PC;
        BOOT_PC: s_d.boot = BOOT_INSN;
        BOOT_INSN: s_d.boot = BOOT_RUN;
        BOOT_RUN: s_d.boot = BOOT_RUN;
        default: s_d.boot = BOOT_HOLD;
      endcase
    end
    s_d.fetch_sp = (s_d.boot == BOOT_SP);
    s_d.fetch_pc = (s_d.boot == BOOT_PC);
    s_d.fetch_insn = (s_d.boot == BOOT_INSN);
    s_d.run = (s_d.boot == BOOT_RUN);

    // Domain resets
    // The test port is only reset while power-on took part in this reset;
    // its pin configuration also follows the pin, and every other source
    // leaves it alone so a debugger stays attached across such resets
    s_d.core_rst_b = ~in_rst; // see [RQ2] [RQ3] [RQ4]
    s_d.tap_rst_b = ~(por_a | (in_rst & s_q.por_flag)); // see [RQ2] [RQ3] [RQ4]
    s_d.tap_pin_rst_b = ~(por_a | ext_a | (in_rst & (s_q.por_flag | s_q.ext_flag))); // see [RQ3]
    s_d.periph_rst_b = ~({NPERIPH{in_rst}} | s_q.prst_act); // see [RQ2] [RQ6]

    // Bus: wait one cycle, then answer; writes land when wait is low
    // The request is taken with wait high, read data are registered then and
    // stand in the next cycle, when wait is low; the write takes effect at
    // the edge that ends that cycle, so a master that holds its request
    // until it sees wait low lands exactly one write
    s_d.sys_req = 1'b0;
    if ((AVS_READ_IN | AVS_WRITE_IN) & s_q.waitreq) begin
      s_d.waitreq = 1'b0;
      // Read mux, unmapped words read zero
      case (AVS_ADDRESS_IN)
        OFS_IDENT_A: rd = IDENT_A; // see [RQ13]
        OFS_IDENT_B: rd = IDENT_B; // see [RQ13]
        OFS_BOR_CTRL: rd[BOR_RSTEN_BIT] = s_q.bor_en;
        OFS_CAUSE: rd[CAUSE_W-1:0] = s_q.cause;
        OFS_PRST: rd[NPERIPH-1:0] = s_q.prst_reg;
        OFS_IRQ_STAT: rd[IRQ_W-1:0] = s_q.irq_stat;
        OFS_IRQ_MASK: rd[IRQ_W-1:0] = s_q.irq_mask;
        default: begin
          // Capability words sit in a block of five
          if (AVS_ADDRESS_IN >= OFS_CAP0 && AVS_ADDRESS_IN <= OFS_CAP4 &&
              AVS_ADDRESS_IN[1:0] == 2'h0) begin
            rd = CAP_TAB[3'(AVS_ADDRESS_IN[4:2] - OFS_CAP0[4:2])]; // see [RQ13]
          end
        end
      endcase
      s_d.rdata = rd;
    end else if (~s_q.waitreq) begin
      s_d.waitreq = 1'b1;
      wr_acc = AVS_WRITE_IN;
    end
    wmask = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}},
             {8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};
    wval = AVS_WRITEDATA_IN & wmask;

    // Register writes; identification and capability words ignore them
    if (wr_acc) begin
      case (AVS_ADDRESS_IN)
        OFS_BOR_CTRL: begin
          if (wmask[BOR_RSTEN_BIT]) begin
            s_d.bor_en = wval[BOR_RSTEN_BIT]; // see [RQ14]
          end
        end
        OFS_CORE_CTRL: s_d.sys_req = wval[SYS_REQ_BIT]; // see [RQ5]
        OFS_CAUSE: s_d.cause = s_q.cause & ~wval[CAUSE_W-1:0];
        OFS_PRST: begin
          prst_new = (s_q.prst_reg & ~wmask[NPERIPH-1:0]) | wval[NPERIPH-1:0];
        end
        OFS_IRQ_STAT: s_d.irq_stat = s_q.irq_stat & ~wval[IRQ_W-1:0];
        OFS_IRQ_MASK: s_d.irq_mask = wval[IRQ_W-1:0];
        default: begin
          // Read-only or unmapped: nothing stored
        end
      endcase
    end

    // Peripheral reset pulses on a set-then-cleared bit
    // A clearing write during a running pulse restarts the count and widens
    // the set of peripherals held; all of them are freed together, which
    // keeps one shared counter instead of one per peripheral
    s_d.prst_reg = prst_new;
    falls = s_q.prst_reg & ~prst_new; // see [RQ15]
    if (falls != '0) begin
      s_d.prst_act = s_q.prst_act | falls; // see [RQ6] [RQ15]
      s_d.prst_cnt = PW'(PRST_HOLD_CYC);
    end else if (s_q.prst_cnt != '0) begin
      s_d.prst_cnt = s_q.prst_cnt - 1'b1;
      if (s_q.prst_cnt == PW'(1)) begin
        s_d.prst_act = '0;
        irq_ev[IRQ_PRST_BIT] = 1'b1;
      end
    end

    // Cause record; the event set wins over a software clear
    // Power-on outranks the pin when both are live, and either one wipes
    // older causes; the other sources only add their bit, so software can
    // still see every reset since the last power-on or pin reset
    if (por_a) begin
      s_d.cause = '0; // see [RQ8]
      s_d.cause[CAUSE_POR_BIT] = 1'b1; // see [RQ7]
    end else if (ext_a) begin
      s_d.cause = '0; // see [RQ8]
      s_d.cause[CAUSE_EXT_BIT] = 1'b1; // see [RQ7]
    end
    if (bor_a) begin
      s_d.cause[CAUSE_BOR_BIT] = 1'b1; // see [RQ7]
    end
    if (wdt_ev) begin
      s_d.cause[CAUSE_WDT_BIT] = 1'b1; // see [RQ7]
    end
    if (s_q.sys_req) begin
      s_d.cause[CAUSE_SW_BIT] = 1'b1; // see [RQ7]
    end

    // Brown-out with reset disabled raises an interrupt instead
    irq_ev[IRQ_BOR_BIT] = s_q.sync2[SY_BOR] & ~s_q.bor_prev & ~s_q.bor_en;
    s_d.irq_stat = s_d.irq_stat | irq_ev;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end

  // State register with synchronous active-low reset
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      s_q <= '0;
      // Lanes start with power-on active and the pin released, so that leaving
      // controller reset neither ends the power-on phase nor fakes a pin reset
      s_q.sync1 <= SYNC_RST; // see [RQ10] [RQ16]
      s_q.sync2 <= SYNC_RST; // see [RQ10] [RQ16]
      s_q.hold_cnt <= HW'(RST_HOLD_CYC);
      s_q.boot <= BOOT_HOLD;
      s_q.cause <= CAUSE_RST;
      s_q.bor_en <= BOR_RSTEN_RST;
      s_q.irq_mask <= IRQ_MASK_RST;
      s_q.waitreq <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  // Every output is a field of the state register, so no decode glitch can
  // reach a reset input of the core or a peripheral
  assign CORE_RST_B_OUT = s_q.core_rst_b;
  assign TAP_RST_B_OUT = s_q.tap_rst_b;
  assign TAP_PIN_RST_B_OUT = s_q.tap_pin_rst_b;
  assign PERIPH_RST_B_OUT = s_q.periph_rst_b;
  assign FETCH_SP_OUT = s_q.fetch_sp;
  assign FETCH_PC_OUT = s_q.fetch_pc;
  assign FETCH_INSN_OUT = s_q.fetch_insn;
  assign CORE_RUN_OUT = s_q.run;
  assign AVS_READDATA_OUT = s_q.rdata;
  assign AVS_WAITREQUEST_OUT = s_q.waitreq;
  assign IRQ_OUT = s_q.irq;
endmodule : rsc_reset_ctrl
`default_nettype wire

// >>> verif/rsc_checker.sv
// Port-level assertions for the reset source controller
`default_nettype none
module rsc_checker
  import rsc_pkg::*;
#(
  parameter int unsigned NPERIPH = 32
) (
  // Clock, reset and watched sources
  input wire logic CLK_SYS_IN,
  input wire logic RST_B_IN,
  input wire logic EXT_RST_B_IN,
  input wire logic WDT_RST_IN,
  // Domain resets
  input wire logic CORE_RST_B_OUT,
  input wire logic TAP_RST_B_OUT,
  input wire logic TAP_PIN_RST_B_OUT,
  input wire logic [NPERIPH-1:0] PERIPH_RST_B_OUT,
  // Boot sequence
  input wire logic FETCH_SP_OUT,
  input wire logic FETCH_PC_OUT,
  input wire logic FETCH_INSN_OUT,
  input wire logic CORE_RUN_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RST_B_IN);
  a_fetch_order: assert property (FETCH_SP_OUT |=> FETCH_PC_OUT ##1 FETCH_INSN_OUT ##1
    CORE_RUN_OUT) else $error("boot fetch order broken");
  a_run_gate: assert property (!CORE_RST_B_OUT |-> !CORE_RUN_OUT)
    else $error("core runs while in reset");
  a_boot_start: assert property ($rose(CORE_RST_B_OUT) |-> ##[0:2] FETCH_SP_OUT)
    else $error("no stack fetch after release");
  a_rel_stretch: assert property ($rose(CORE_RST_B_OUT) |-> !$past(CORE_RST_B_OUT, 20))
    else $error("core reset released too soon");
  a_tap_keep: assert property (TAP_RST_B_OUT |=> TAP_RST_B_OUT)
    else $error("test port reset after power-up");
  a_tap_pin: assert property (!TAP_RST_B_OUT |-> !TAP_PIN_RST_B_OUT)
    else $error("pin config missed power-on reset");
  a_periph_tie: assert property (!CORE_RST_B_OUT |-> PERIPH_RST_B_OUT == '0)
    else $error("peripheral missed system reset");
  a_pin_hold: assert property (!EXT_RST_B_IN [*4] |-> !CORE_RST_B_OUT)
    else $error("core free while pin held");
  a_wdt_reset: assert property ($rose(WDT_RST_IN) && CORE_RUN_OUT |->
    ##[1:6] !CORE_RST_B_OUT) else $error("watchdog did not reset core");
endmodule : rsc_checker
bind rsc_reset_ctrl rsc_checker #(.NPERIPH(NPERIPH)) u_chk (.CLK_SYS_IN(CLK_SYS_IN),
  .RST_B_IN(RST_B_IN), .EXT_RST_B_IN(EXT_RST_B_IN), .WDT_RST_IN(WDT_RST_IN),
  .CORE_RST_B_OUT(CORE_RST_B_OUT), .TAP_RST_B_OUT(TAP_RST_B_OUT),
  .TAP_PIN_RST_B_OUT(TAP_PIN_RST_B_OUT), .PERIPH_RST_B_OUT(PERIPH_RST_B_OUT),
  .FETCH_SP_OUT(FETCH_SP_OUT), .FETCH_PC_OUT(FETCH_PC_OUT),
  .FETCH_INSN_OUT(FETCH_INSN_OUT), .CORE_RUN_OUT(CORE_RUN_OUT));
`default_nettype wire

// >>> verif/rsc_reset_ctrl_tb.sv
// Self-checking bench for the reset source controller
`default_nettype none
module rsc_reset_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rsc_pkg::*;
  localparam logic [31:0] ID_A = 32'h0000_5A01; // Arbitrary value
  localparam logic [31:0] ID_B = 32'h0000_5A02; // Arbitrary value
  localparam logic [31:0] CAP_2 = 32'h0000_C0DE; // Capability word 2
  logic clk, rst_b, por, ext_b, bor, wdt, core_b, tap_b, tpin_b;
  logic sp, pc, insn, run, rd, wr, wreq, irq;
  logic [3:0] be;
  logic [7:0] addr;
  logic [31:0] prst_b, rdata, wdata, q;
  int n_mismatch, total_checks, cyc;
  rsc_reset_ctrl #(.IDENT_A(ID_A), .IDENT_B(ID_B), .CAP2(CAP_2)) dut (.CLK_SYS_IN(clk),
    .RST_B_IN(rst_b),
    .POR_DET_IN(por), .EXT_RST_B_IN(ext_b), .BOR_DET_IN(bor), .WDT_RST_IN(wdt),
    .CORE_RST_B_OUT(core_b), .TAP_RST_B_OUT(tap_b), .TAP_PIN_RST_B_OUT(tpin_b),
    .PERIPH_RST_B_OUT(prst_b), .FETCH_SP_OUT(sp), .FETCH_PC_OUT(pc),
    .FETCH_INSN_OUT(insn), .CORE_RUN_OUT(run), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wreq), .IRQ_OUT(irq));
  rsc_src_model m (.clk_in(clk), .por_det_out(por), .ext_rst_b_out(ext_b),
    .bor_det_out(bor), .wdt_rst_out(wdt));
  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One bus access, held until waitrequest samples low
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    rd <= !we;
    wr <= we;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    chk("bus_answer", 32'(k < 50), 32'h1);
  endtask : bus
  // Wait for the run flag to reach a level
  task automatic wait_run(input logic v);
    int k;
    k = 0;
    while (run !== v && k < 300) begin
      @(posedge clk);
      k++;
    end
    chk("core_run", 32'(run), 32'(v));
  endtask : wait_run
  // Power-up: all domains held until detector drops
  task automatic t_por;
    repeat (15) @(posedge clk);
    chk("tap_por", 32'(tap_b), 32'h0);
    chk("core_por", 32'(core_b), 32'h0);
    chk("periph_por", prst_b, 32'h0);
    m.pulse(0, 0);
    wait_run(1'b1);
    chk("tap_up", 32'(tap_b), 32'h1);
    bus(1'b0, OFS_CAUSE, 32'h0);
    chk("cause_por", q, 32'h2);
  endtask : t_por
  // Read-only identity and an unmapped place
  task automatic t_ident;
    bus(1'b1, OFS_IDENT_A, 32'hFFFF_FFFF);
    bus(1'b0, OFS_IDENT_A, 32'h0);
    chk("ident_a", q, ID_A);
    bus(1'b0, OFS_IDENT_B, 32'h0);
    chk("ident_b", q, ID_B);
    bus(1'b1, OFS_CAP0 + 8'h08, 32'hFFFF_FFFF);
    bus(1'b0, OFS_CAP0 + 8'h08, 32'h0);
    chk("cap_2", q, CAP_2);
    bus(1'b0, 8'h3C, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask : t_ident
  // Watchdog, then system request; causes accumulate, test port spared
  task automatic t_wdt_sys;
    m.pulse(3, 2);
    wait_run(1'b0);
    wait_run(1'b1);
    bus(1'b1, OFS_CORE_CTRL, 32'h4);
    wait_run(1'b0);
    wait_run(1'b1);
    chk("tap_sw", 32'(tap_b), 32'h1);
    bus(1'b0, OFS_CAUSE, 32'h0);
    chk("cause_sticky", q, 32'h1A);
  endtask : t_wdt_sys
  // Long pin hold: pin config only, other causes cleared
  task automatic t_pin;
    m.pulse(1, 40);
    chk("core_pin", 32'(core_b), 32'h0);
    chk("tpin_pin", 32'(tpin_b), 32'h0);
    chk("tap_pin", 32'(tap_b), 32'h1);
    wait_run(1'b1);
    bus(1'b0, OFS_CAUSE, 32'h0);
    chk("cause_ext", q, 32'h1);
  endtask : t_pin
  // Brown-out ignored while disabled, raising an interrupt; then a reset
  task automatic t_bor;
    bus(1'b0, OFS_BOR_CTRL, 32'h0);
    chk("bor_ctrl_rst", q, 32'h0);
    m.pulse(2, 8);
    repeat (4) @(posedge clk);
    chk("core_bor_off", 32'(core_b), 32'h1);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("stat_bor", q, 32'h1);
    chk("irq_masked", 32'(irq), 32'h0);
    bus(1'b1, OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_on", 32'(irq), 32'h1);
    bus(1'b1, OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_clr", 32'(irq), 32'h0);
    bus(1'b1, OFS_BOR_CTRL, 32'h2);
    m.pulse(2, 40);
    chk("core_bor_on", 32'(core_b), 32'h0);
    wait_run(1'b1);
    bus(1'b0, OFS_CAUSE, 32'h0);
    chk("cause_bor", q, 32'h5);
    be <= 4'hE;
    bus(1'b1, OFS_BOR_CTRL, 32'h0);
    be <= 4'hF;
    bus(1'b0, OFS_BOR_CTRL, 32'h0);
    chk("bor_be", q, 32'h2);
    bus(1'b1, OFS_CAUSE, 32'h4);
    bus(1'b0, OFS_CAUSE, 32'h0);
    chk("cause_w1c", q, 32'h1);
  endtask : t_bor
  // Peripheral 3 set then cleared: only it pulses, for the set width
  task automatic t_prst;
    int k;
    bus(1'b1, OFS_PRST, 32'h8);
    bus(1'b1, OFS_PRST, 32'h0);
    k = 0;
    while (prst_b[3] !== 1'b0 && k < 5) begin
      @(posedge clk);
      k++;
    end
    chk("prst_one", prst_b, 32'hFFFF_FFF7);
    chk("core_prst", 32'(core_b), 32'h1);
    k = 0;
    while (prst_b[3] === 1'b0 && k < 40) begin
      @(posedge clk);
      k++;
    end
    chk("prst_width", 32'(k), PRST_HOLD_CYC);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("stat_prst", q, 32'h2);
  endtask : t_prst
  // Verdict and end of run
  task automatic test_done;
    if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      test_done;
    end
  end
  // Main sequence
  initial begin
    rst_b = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    be = 4'hF;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_por;
    t_ident;
    t_wdt_sys;
    t_pin;
    t_bor;
    t_prst;
    test_done;
  end
endmodule : rsc_reset_ctrl_tb
`default_nettype wire

// >>> verif/rsc_src_model.sv
// Model of the reset pin circuit, supply detectors and watchdog
`default_nettype none
module rsc_src_model #(
  parameter int unsigned MIN_PULSE_CYC = 4 // Least pin low time in cycles
) (
  // Clock
  input wire logic clk_in,
  // Source lines
  output logic por_det_out,
  output logic ext_rst_b_out,
  output logic bor_det_out,
  output logic wdt_rst_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Supply ramps at power-up, so the detector starts active; pin rests on its pull-up
  initial begin
    por_det_out = 1'b1;
    ext_rst_b_out = 1'b1;
    bor_det_out = 1'b0;
    wdt_rst_out = 1'b0;
  end
  // Raise one source for n cycles; 0 power-on, 1 pin, 2 brown-out, 3 watchdog
  task automatic pulse(input int sel, input int n);
    @(posedge clk_in);
    case (sel)
      0: por_det_out <= 1'b0; // Drops once and stays low
      1: ext_rst_b_out <= 1'b0;
      2: bor_det_out <= 1'b1;
      default: wdt_rst_out <= 1'b1;
    endcase
    repeat ((sel == 1 && n < MIN_PULSE_CYC) ? MIN_PULSE_CYC : n) @(posedge clk_in);
    ext_rst_b_out <= 1'b1;
    bor_det_out <= 1'b0;
    wdt_rst_out <= 1'b0;
  endtask : pulse
endmodule : rsc_src_model
`default_nettype wire
